//--- hdl/fqt_pkg.sv
package fqt_pkg;

    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          IDX_W           = 10;
    localparam int          CNT_W           = 16;

    // Register indexes; byte address is four times the index
    localparam logic [9:0]  IDX_CTRL        = 10'h000;
    localparam logic [9:0]  IDX_STATUS      = 10'h001;
    localparam logic [9:0]  IDX_TBL_FIRST   = 10'h10A;
    localparam logic [9:0]  IDX_SIG_0       = 10'h10A;
    localparam logic [9:0]  IDX_SIG_1       = 10'h10B;
    localparam logic [9:0]  IDX_SIG_2       = 10'h10C;
    localparam logic [9:0]  IDX_VER_MAJ     = 10'h10D;
    localparam logic [9:0]  IDX_VER_MIN     = 10'h10E;
    localparam logic [9:0]  IDX_FEAT_0      = 10'h10F;
    localparam logic [9:0]  IDX_FEAT_1      = 10'h110;
    localparam logic [9:0]  IDX_FEAT_2      = 10'h111;
    localparam logic [9:0]  IDX_FEAT_3      = 10'h112;
    localparam logic [9:0]  IDX_AFTER_SUSP  = 10'h113;
    localparam logic [9:0]  IDX_BSM_0       = 10'h114;
    localparam logic [9:0]  IDX_BSM_1       = 10'h115;
    localparam logic [9:0]  IDX_VCC_PE      = 10'h116;
    localparam logic [9:0]  IDX_VPP_PE      = 10'h117;
    localparam logic [9:0]  IDX_PROT_CNT    = 10'h118;
    localparam logic [9:0]  IDX_PD1_0       = 10'h119;
    localparam logic [9:0]  IDX_PD1_2       = 10'h11B;
    localparam logic [9:0]  IDX_PD1_3       = 10'h11C;
    localparam logic [9:0]  IDX_PD2_0       = 10'h11D;
    localparam logic [9:0]  IDX_PD2_UGRP_LO = 10'h124;
    localparam logic [9:0]  IDX_PD2_USIZE   = 10'h126;
    localparam logic [9:0]  IDX_TBL_LAST    = 10'h126;

    // Table byte values
    localparam logic [7:0]  TBL_SIG_0       = 8'h50;
    localparam logic [7:0]  TBL_SIG_1       = 8'h52;
    localparam logic [7:0]  TBL_SIG_2       = 8'h49;
    localparam logic [7:0]  TBL_VER_MAJ     = 8'h31;
    localparam logic [7:0]  TBL_VER_MIN     = 8'h34;
    localparam logic [7:0]  TBL_FEAT_0      = 8'hE6;
    localparam logic [7:0]  TBL_FEAT_1      = 8'h01;
    localparam logic [7:0]  TBL_LINK_DIE1   = 8'h40;
    localparam logic [7:0]  TBL_LINK_NONE   = 8'h00;
    localparam logic [7:0]  TBL_AFTER_SUSP  = 8'h01;
    localparam logic [7:0]  TBL_BSM_0       = 8'h03;
    localparam logic [7:0]  TBL_VCC_PE      = 8'h18;
    localparam logic [7:0]  TBL_VPP_PE      = 8'h90;
    localparam logic [7:0]  TBL_PROT_CNT    = 8'h02;
    localparam logic [7:0]  TBL_PD1_0       = 8'h80;
    localparam logic [7:0]  TBL_PD1_2       = 8'h03;
    localparam logic [7:0]  TBL_PD1_3       = 8'h03;
    localparam logic [7:0]  TBL_PD2_0       = 8'h89;
    localparam logic [7:0]  TBL_PD2_UGRP_LO = 8'h10;
    localparam logic [7:0]  TBL_PD2_USIZE   = 8'h04;
    localparam logic [7:0]  TBL_ZERO        = 8'h00;

    // Own control and status fields
    localparam int          CTRL_QUERY_BIT  = 0;
    localparam logic        CTRL_QUERY_RST  = 1'b0;
    localparam int          STAT_QUERY_BIT  = 16;

    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    localparam logic [1:0]  RESP_DECERR     = 2'b11;

    typedef enum logic [1:0] {
        FQT_RD_IDLE = 2'b00,
        FQT_RD_LOOK = 2'b01,
        FQT_RD_RESP = 2'b10
    } fqt_rd_state_t;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic [2:0]        awprot;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic [2:0]        arprot;
        logic              rready;
    } fqt_axil_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } fqt_axil_rsp_t;

    function automatic logic [IDX_W-1:0] fqt_addr_idx(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2];
    endfunction : fqt_addr_idx

    function automatic logic fqt_in_table(input logic [IDX_W-1:0] idx);
        return (idx >= IDX_TBL_FIRST) && (idx <= IDX_TBL_LAST);
    endfunction : fqt_in_table

endpackage : fqt_pkg

//--- hdl/fqt_table.sv
`timescale 1ns/1ns
`default_nettype none
module fqt_table #(
    parameter logic [7:0] LINK_BYTE = 8'h00
) (
    input  wire logic                    clk,   // System clock
    input  wire logic                    rst,   // Synchronous reset
    input  wire logic [fqt_pkg::IDX_W-1:0] idx, // Word index of the query byte
    output logic [7:0]                   q      // Registered table byte
);
    import fqt_pkg::*;

    typedef struct packed {
        logic [7:0] q;
    } fqt_tbl_state_t;

    fqt_tbl_state_t st_ff;
    fqt_tbl_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        case (idx)
            IDX_SIG_0:       nxt_st.q = TBL_SIG_0;         // R1
            IDX_SIG_1:       nxt_st.q = TBL_SIG_1;         // R1
            IDX_SIG_2:       nxt_st.q = TBL_SIG_2;         // R1
            IDX_VER_MAJ:     nxt_st.q = TBL_VER_MAJ;       // R2
            IDX_VER_MIN:     nxt_st.q = TBL_VER_MIN;       // R2
            IDX_FEAT_0:      nxt_st.q = TBL_FEAT_0;        // R4
            IDX_FEAT_1:      nxt_st.q = TBL_FEAT_1;        // R4
            IDX_FEAT_3:      nxt_st.q = LINK_BYTE;         // R5
            IDX_AFTER_SUSP:  nxt_st.q = TBL_AFTER_SUSP;    // R6
            IDX_BSM_0:       nxt_st.q = TBL_BSM_0;         // R7
            IDX_VCC_PE:      nxt_st.q = TBL_VCC_PE;        // R8
            IDX_VPP_PE:      nxt_st.q = TBL_VPP_PE;        // R9
            IDX_PROT_CNT:    nxt_st.q = TBL_PROT_CNT;      // R10
            IDX_PD1_0:       nxt_st.q = TBL_PD1_0;         // R11
            IDX_PD1_2:       nxt_st.q = TBL_PD1_2;         // R11
            IDX_PD1_3:       nxt_st.q = TBL_PD1_3;         // R11
            IDX_PD2_0:       nxt_st.q = TBL_PD2_0;         // R12
            IDX_PD2_UGRP_LO: nxt_st.q = TBL_PD2_UGRP_LO;   // R12
            IDX_PD2_USIZE:   nxt_st.q = TBL_PD2_USIZE;     // R12
            // Reserved feature bits, high bytes and zero groups
            default:         nxt_st.q = TBL_ZERO;          // R3
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;

endmodule : fqt_table
`default_nettype wire

//--- hdl/fqt_ctrl_reg.sv
`timescale 1ns/1ns
`default_nettype none
module fqt_ctrl_reg (
    input  wire logic                        clk,        // System clock
    input  wire logic                        rst,        // Synchronous reset
    input  wire logic                        wr_en,      // One-cycle write pulse
    input  wire logic [fqt_pkg::DATA_W-1:0]  wr_data,    // Write data
    input  wire logic [3:0]                  wr_strb,    // Byte strobes
    output logic                             query_mode  // Query read mode
);
    import fqt_pkg::*;

    typedef struct packed {
        logic query;
    } fqt_ctrl_state_t;

    fqt_ctrl_state_t st_ff;
    fqt_ctrl_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (wr_en && wr_strb[0]) begin
            nxt_st.query = wr_data[CTRL_QUERY_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff.query <= CTRL_QUERY_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign query_mode = st_ff.query;

endmodule : fqt_ctrl_reg
`default_nettype wire

//--- hdl/fqt_query_table.sv
// Contract
// R1 - Signature bytes 50h, 52h, 49h at the first three table addresses.
// R2 - Version reads 31h major then 34h minor.
// R3 - Feature bits 11 to 29 read zero; bit 31 flags another field.
// R4 - Feature low bytes read E6h then 01h.
// R5 - Byte 112h reads 40h on stacked die 1, else 00h.
// R6 - After-suspend byte reads 01h; upper bits zero.
// R7 - Block status mask reads 03h then 00h.
// R8 - Core program/erase voltage byte reads 18h in BCD.
// R9 - Programming supply voltage byte reads 90h.
// R10 - Protection field count reads 02h; host treats 00h as 256.
// R11 - First protection descriptor reads 80h, 00h, 03h, 03h.
// R12 - Second descriptor: lock word 89h, zero factory, 10h groups, size 04h.
// R13 - Table bytes appear on the low byte only in query read mode.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module fqt_query_table #(
    parameter logic [7:0] LINK_BYTE = fqt_pkg::TBL_LINK_NONE
) (
    input  wire logic                    clk,     // System clock, 125 MHz
    input  wire logic                    rst,     // Synchronous reset, active high
    input  wire fqt_pkg::fqt_axil_req_t  axi_req, // AXI4-Lite master to slave
    output fqt_pkg::fqt_axil_rsp_t       axi_rsp, // AXI4-Lite slave to master
    output logic                         query_on // Query read mode is active
);
    import fqt_pkg::*;

    typedef struct packed {
        logic                 awready;
        logic                 wready;
        logic                 aw_held;
        logic                 w_held;
        logic [IDX_W-1:0]     aw_idx;
        logic [DATA_W-1:0]    wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        fqt_rd_state_t        rd_state;
        logic [IDX_W-1:0]     rd_idx;
        logic                 rd_query;
        logic                 rvalid;
        logic [DATA_W-1:0]    rdata;
        logic [1:0]           rresp;
        logic [CNT_W-1:0]     rd_cnt;
    } fqt_state_t;

    fqt_state_t         st_ff;
    fqt_state_t         nxt_st;
    logic               query_mode;
    logic [7:0]         rom_q;
    logic               ctrl_wr;
    logic               wr_commit;
    logic [IDX_W-1:0]   ar_idx;

    assign ar_idx    = fqt_addr_idx(axi_req.araddr);
    assign wr_commit = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    assign ctrl_wr   = wr_commit && (st_ff.aw_idx == IDX_CTRL);

    // Table lookup is fed from the address bus so the byte is ready one cycle after the handshake
    fqt_table #(
        .LINK_BYTE (LINK_BYTE)
    ) u_table (
        .clk       (clk),
        .rst       (rst),
        .idx       (ar_idx),
        .q         (rom_q)
    );

    fqt_ctrl_reg u_ctrl (
        .clk        (clk),
        .rst        (rst),
        .wr_en      (ctrl_wr),
        .wr_data    (st_ff.wdata),
        .wr_strb    (st_ff.wstrb),
        .query_mode (query_mode)
    );

    always_comb begin
        nxt_st = st_ff;

        // Write address and data are taken in either order
        if (axi_req.awvalid && st_ff.awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_idx  = fqt_addr_idx(axi_req.awaddr);
            nxt_st.awready = 1'b0;
        end
        if (axi_req.wvalid && st_ff.wready) begin
            nxt_st.w_held  = 1'b1;
            nxt_st.wdata   = axi_req.wdata;
            nxt_st.wstrb   = axi_req.wstrb;
            nxt_st.wready  = 1'b0;
        end
        if (wr_commit) begin
            nxt_st.bvalid  = 1'b1;
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            if (st_ff.aw_idx == IDX_CTRL) begin
                nxt_st.bresp = RESP_OKAY;
            end else if ((st_ff.aw_idx == IDX_STATUS) || fqt_in_table(st_ff.aw_idx)) begin
                // Table and status are read only
                nxt_st.bresp = RESP_SLVERR;
            end else begin
                nxt_st.bresp = RESP_DECERR;
            end
        end
        if (st_ff.bvalid && axi_req.bready) begin
            nxt_st.bvalid  = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready  = 1'b1;
        end

        case (st_ff.rd_state)
            FQT_RD_IDLE: begin
                if (axi_req.arvalid && st_ff.arready) begin
                    nxt_st.arready  = 1'b0;
                    nxt_st.rd_idx   = ar_idx;
                    nxt_st.rd_query = query_mode;
                    nxt_st.rd_state = FQT_RD_LOOK;
                end
            end
            FQT_RD_LOOK: begin
                nxt_st.rvalid   = 1'b1;
                nxt_st.rd_state = FQT_RD_RESP;
                if (st_ff.rd_idx == IDX_CTRL) begin
                    nxt_st.rdata = '0;
                    nxt_st.rdata[CTRL_QUERY_BIT] = st_ff.rd_query;
                    nxt_st.rresp = RESP_OKAY;
                end else if (st_ff.rd_idx == IDX_STATUS) begin
                    nxt_st.rdata = {{(DATA_W-CNT_W){1'b0}}, st_ff.rd_cnt};
                    nxt_st.rdata[STAT_QUERY_BIT] = st_ff.rd_query;
                    nxt_st.rresp = RESP_OKAY;
                end else if (fqt_in_table(st_ff.rd_idx)) begin
                    nxt_st.rresp = RESP_OKAY;
                    if (st_ff.rd_query) begin
                        nxt_st.rdata  = {24'h000000, rom_q};                            // R13
                        nxt_st.rd_cnt = st_ff.rd_cnt + 16'h0001;
                    end else begin
                        nxt_st.rdata  = '0;                                             // R13
                    end
                end else begin
                    nxt_st.rdata = '0;
                    nxt_st.rresp = RESP_DECERR;
                end
            end
            FQT_RD_RESP: begin
                if (axi_req.rready) begin
                    nxt_st.rvalid   = 1'b0;
                    nxt_st.arready  = 1'b1;
                    nxt_st.rd_state = FQT_RD_IDLE;
                end
            end
            default: begin
                nxt_st.rvalid   = 1'b0;
                nxt_st.arready  = 1'b1;
                nxt_st.rd_state = FQT_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff          <= '0;
            st_ff.awready  <= 1'b1;
            st_ff.wready   <= 1'b1;
            st_ff.arready  <= 1'b1;
            st_ff.rd_state <= FQT_RD_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign axi_rsp.awready = st_ff.awready;
    assign axi_rsp.wready  = st_ff.wready;
    assign axi_rsp.bvalid  = st_ff.bvalid;
    assign axi_rsp.bresp   = st_ff.bresp;
    assign axi_rsp.arready = st_ff.arready;
    assign axi_rsp.rvalid  = st_ff.rvalid;
    assign axi_rsp.rdata   = st_ff.rdata;
    assign axi_rsp.rresp   = st_ff.rresp;
    assign query_on        = query_mode;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_ar_take(logic [IDX_W-1:0] idx, logic qm);
        axi_req.arvalid && st_ff.arready && (ar_idx == idx) && (query_mode == qm);
    endsequence

    sequence s_byte_out(logic [7:0] val);
        st_ff.rvalid && (st_ff.rdata == {24'h000000, val}) && (st_ff.rresp == RESP_OKAY);
    endsequence

    property p_tbl_byte(logic [IDX_W-1:0] idx, logic [7:0] val);
        s_ar_take(idx, 1'b1) |-> ##2 s_byte_out(val);
    endproperty

    a_sig_first:     assert property (p_tbl_byte(IDX_SIG_0, TBL_SIG_0))   // R1
        else $error("signature byte 0 wrong");
    a_sig_last:      assert property (p_tbl_byte(IDX_SIG_2, TBL_SIG_2))   // R1
        else $error("signature byte 2 wrong");
    a_ver_major:     assert property (p_tbl_byte(IDX_VER_MAJ, TBL_VER_MAJ)) // R2
        else $error("major version wrong");
    a_ver_minor:     assert property (p_tbl_byte(IDX_VER_MIN, TBL_VER_MIN)) // R2
        else $error("minor version wrong");
    a_feat_resv:     assert property (p_tbl_byte(IDX_FEAT_2, TBL_ZERO))   // R3
        else $error("reserved feature bits not zero");
    a_feat_low:      assert property (p_tbl_byte(IDX_FEAT_0, TBL_FEAT_0)) // R4
        else $error("feature low byte wrong");
    a_link_byte:     assert property (p_tbl_byte(IDX_FEAT_3, LINK_BYTE))  // R5
        else $error("link byte wrong");
    a_after_susp:    assert property (p_tbl_byte(IDX_AFTER_SUSP, TBL_AFTER_SUSP)) // R6
        else $error("after-suspend byte wrong");
    a_mask_low:      assert property (p_tbl_byte(IDX_BSM_0, TBL_BSM_0))   // R7
        else $error("block status mask wrong");
    a_core_volt:     assert property (p_tbl_byte(IDX_VCC_PE, TBL_VCC_PE)) // R8
        else $error("core voltage byte wrong");
    a_prog_volt:     assert property (p_tbl_byte(IDX_VPP_PE, TBL_VPP_PE)) // R9
        else $error("programming voltage byte wrong");
    a_prot_count:    assert property (p_tbl_byte(IDX_PROT_CNT, TBL_PROT_CNT)) // R10
        else $error("protection field count wrong");
    a_desc_one:      assert property (p_tbl_byte(IDX_PD1_0, TBL_PD1_0))   // R11
        else $error("first descriptor byte wrong");
    a_desc_two:      assert property (p_tbl_byte(IDX_PD2_USIZE, TBL_PD2_USIZE)) // R12
        else $error("group size code wrong");

    a_query_gate:    assert property (                                     // R13
        (axi_req.arvalid && st_ff.arready && fqt_in_table(ar_idx) && !query_mode)
        |-> ##2 (st_ff.rvalid && (st_ff.rdata == '0)))
        else $error("table byte visible outside query mode");

    a_rdata_hold:    assert property (
        (st_ff.rvalid && !axi_req.rready) |=> (st_ff.rvalid && $stable(st_ff.rdata)))
        else $error("read data changed before it was taken");

    a_write_resp:    assert property (
        (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) |=> st_ff.bvalid)
        else $error("write response not raised");

endmodule : fqt_query_table
`default_nettype wire

//--- testbench/fqt_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module fqt_host_model (
    input  wire logic                   clk,     // System clock
    input  wire fqt_pkg::fqt_axil_rsp_t axi_rsp, // Slave answers
    output var  fqt_pkg::fqt_axil_req_t axi_req  // Master requests
);
    import fqt_pkg::*;

    initial axi_req = '0;

    // Query read: hold the address until taken, then wait dly cycles before accepting data
    task automatic rd(input logic [ADDR_W-1:0] addr, input int dly,
                      output logic [DATA_W-1:0] data, output logic [1:0] resp);
        @(posedge clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= addr;
        do @(posedge clk); while (axi_rsp.arready !== 1'b1);
        axi_req.arvalid <= 1'b0;
        axi_req.araddr  <= ~addr;
        repeat (dly) @(posedge clk);
        axi_req.rready <= 1'b1;
        do @(posedge clk); while (axi_rsp.rvalid !== 1'b1);
        data = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask : rd

    // Address and data offered together, each released once taken
    task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
                      input logic [3:0] strb, input int dly, output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= addr;
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= data;
        axi_req.wstrb   <= strb;
        do begin
            @(posedge clk);
            if (!aw_ok && axi_rsp.awready === 1'b1) begin
                aw_ok = 1'b1;
                axi_req.awvalid <= 1'b0;
                axi_req.awaddr  <= ~addr;
            end
            if (!w_ok && axi_rsp.wready === 1'b1) begin
                w_ok = 1'b1;
                axi_req.wvalid <= 1'b0;
                axi_req.wdata  <= ~data;
            end
        end while (!(aw_ok && w_ok));
        repeat (dly) @(posedge clk);
        axi_req.bready <= 1'b1;
        do @(posedge clk); while (axi_rsp.bvalid !== 1'b1);
        resp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask : wr
endmodule : fqt_host_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import fqt_pkg::*;

    localparam logic [7:0] LINK = 8'h40;
    // Expected table bytes from index 10Ah up
    localparam logic [7:0] EXP_TBL [0:28] = '{
        8'h50, 8'h52, 8'h49, 8'h31, 8'h34,
        8'hE6, 8'h01, 8'h00, LINK,
        8'h01, 8'h03, 8'h00, 8'h18, 8'h90,
        8'h02, 8'h80, 8'h00, 8'h03, 8'h03,
        8'h89, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h10, 8'h00, 8'h04};

    logic          clk;
    logic          rst          = 1'b1;
    fqt_axil_req_t axi_req;
    fqt_axil_rsp_t axi_rsp;
    logic          query_on;
    int            bad_count    = 0;
    int            total_checks = 0;
    int            seed         = 32'h0A02E695;
    int            qcount       = 0;
    logic [31:0]   feat;

    fqt_query_table #(.LINK_BYTE(LINK)) fqt_query_table_i (
        .clk      (clk),
        .rst      (rst),
        .axi_req  (axi_req),
        .axi_rsp  (axi_rsp),
        .query_on (query_on)
    );

    fqt_host_model fqt_host_model_i (
        .clk     (clk),
        .axi_rsp (axi_rsp),
        .axi_req (axi_req)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_data

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_resp

    task automatic chk_flag(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag

    function automatic int rnd_dly();
        return $random(seed) & 3;
    endfunction : rnd_dly

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp,
                          output logic [31:0] got);
        logic [1:0] resp;
        fqt_host_model_i.rd(addr, rnd_dly(), got, resp);
        chk_data($sformatf("rdata at %h", addr), exp, got);
        chk_resp($sformatf("rresp at %h", addr), exp_resp, resp);
    endtask : rd_chk

    task automatic wr_chk(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb,
                          input logic [1:0] exp_resp);
        logic [1:0] resp;
        fqt_host_model_i.wr(addr, data, strb, rnd_dly(), resp);
        chk_resp($sformatf("bresp at %h", addr), exp_resp, resp);
    endtask : wr_chk

    // Table read; a byte shows only while query mode is on
    task automatic tbl_rd(input int n, input logic on, output logic [31:0] got);
        rd_chk(12'(({2'b00, IDX_TBL_FIRST} + n) * 4), on ? {24'h0, EXP_TBL[n]} : 32'h0, RESP_OKAY, got);
        if (on) qcount++;
    endtask : tbl_rd

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("CHECK FAILED watchdog expected done seen hang");
        test_done();
    end

    initial begin
        logic [31:0] d;
        int          n;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_flag("query_on after reset", 1'b0, query_on);
        tbl_rd(0, 1'b0, d);
        rd_chk(12'h004, 32'h0, RESP_OKAY, d);
        wr_chk(12'h000, 32'h1, 4'h0, RESP_OKAY);
        chk_flag("query_on masked write", 1'b0, query_on);
        wr_chk(12'h000, $random(seed) | 32'h1, 4'hF, RESP_OKAY);
        chk_flag("query_on set", 1'b1, query_on);
        for (n = 0; n < 29; n++) begin
            tbl_rd(n, 1'b1, d);
            if (n >= 5 && n <= 8) feat[8*(n-5) +: 8] = d[7:0];
        end
        chk_data("feature reserved bits", 32'h0, feat & 32'h3FFF_F800);
        chk_flag("feature link bit", 1'b1, feat[30]);
        chk_flag("feature more fields", 1'b0, feat[31]);
        repeat (40) begin
            n = $random(seed);
            tbl_rd(n[30:0] % 29, 1'b1, d);
        end
        wr_chk(12'h428, 32'h0, 4'hF, RESP_SLVERR);
        wr_chk(12'h004, 32'h0, 4'hF, RESP_SLVERR);
        wr_chk(12'hFFC, 32'h0, 4'hF, RESP_DECERR);
        rd_chk(12'h49C, 32'h0, RESP_DECERR, d);
        rd_chk(12'h800, 32'h0, RESP_DECERR, d);
        tbl_rd(0, 1'b1, d);
        rd_chk(12'h004, {15'h0, 1'b1, 16'(qcount)}, RESP_OKAY, d);
        rd_chk(12'h000, 32'h1, RESP_OKAY, d);
        wr_chk(12'h000, 32'h0, 4'h1, RESP_OKAY);
        chk_flag("query_on cleared", 1'b0, query_on);
        tbl_rd(3, 1'b0, d);
        rd_chk(12'h004, {15'h0, 1'b0, 16'(qcount)}, RESP_OKAY, d);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
